// file: hdl/adc_byte_wide_host_port.sv
// Byte-wide parallel host port of a 10-bit converter: configuration
// write, acquisition timing, result readout and completion flag.
// Assumes all host pins are asynchronous and the conversion core gives a
// one-cycle done pulse with its result on the same cycle.
`timescale 1ns/1ps
`include "adc_port_defs.svh"

module adc_byte_wide_host_port #(
    parameter logic [7:0] OSC_DIV = `OSC_DIV_DEFAULT
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        high_byte_select,
    input  wire logic [7:0]  data_bus_lines_in,
    input  wire logic        conv_clk_pin,
    input  wire logic        ext_clk_mode,
    input  wire logic        core_done,
    input  wire logic [9:0]  core_result,
    output logic      [7:0]  data_bus_lines_out,
    output logic             data_bus_lines_oe,
    output logic             conv_done_n_out,
    output logic             conv_done_n_oe,
    output logic             track_hold,
    output logic             conv_start,
    output logic      [7:0]  config_byte
);

    adc_port_pkg::port_state_t st_r;
    adc_port_pkg::port_state_t st_nxt;
    logic [`SYNC_W-1:0]        sync_q;
    logic                      cs_s;
    logic                      rd_s;
    logic                      wr_s;
    logic                      hb_s;
    logic                      clk_s;
    logic [7:0]                data_s;

    // Host pins are asynchronous, so all but ext_clk_mode pass two flops first.
    pin_sync #(
        .WIDTH   (`SYNC_W),
        .RST_VAL (`SYNC_RESET)
    ) u_sync (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .pin_in       ({conv_clk_pin, high_byte_select, wr_n, rd_n, cs_n,
                        data_bus_lines_in}),
        .pin_sync_out (sync_q)
    );

    assign {clk_s, hb_s, wr_s, rd_s, cs_s, data_s} = sync_q;

    // Next-state logic. The data byte and write strobe share the same
    // synchroniser delay, so the byte is taken with the strobe's rise;
    // the host must hold data valid a few cycles past the rise.
    always_comb
    begin
        logic fall_ev;
        logic osc_tick;
        logic wr_rise;
        logic rd_fall;
        fall_ev  = 1'b0;
        osc_tick = 1'b0;
        wr_rise  = 1'b0;
        rd_fall  = 1'b0;
        st_nxt   = st_r;
        st_nxt.conv_start = 1'b0;
        st_nxt.wr_d  = wr_s;
        st_nxt.rd_d  = rd_s;
        st_nxt.clk_d = clk_s;

        // Internal oscillator stands in for the on-chip clock.
        osc_tick = (st_r.osc_cnt == OSC_DIV - 8'h01);
        st_nxt.osc_cnt = osc_tick ? 8'h00 : st_r.osc_cnt + 8'h01;

        // External mode relies on the host clocking the pin.
        fall_ev = ext_clk_mode ? (st_r.clk_d & ~clk_s) : osc_tick;
        wr_rise = ~st_r.wr_d & wr_s & ~cs_s;
        rd_fall = st_r.rd_d & ~rd_s & ~cs_s;

        // A read strobe fall clears the completion flag.
        if (rd_fall)
            st_nxt.done_n = 1'b1;

        case (st_r.phase)
            adc_port_pkg::ST_IDLE:
            begin
                if (wr_rise)
                begin
                    st_nxt.cfg      = data_s;
                    st_nxt.hold     = 1'b0;
                    st_nxt.fall_cnt = 3'h0;
                    if (data_s[`CFG_ACQ_BIT])
                        st_nxt.phase = adc_port_pkg::ST_TRACK_EXT;
                    else
                        st_nxt.phase = adc_port_pkg::ST_TRACK_INT;
                end
            end
            adc_port_pkg::ST_TRACK_INT:
            begin
                // Hold comes on the fourth falling clock edge.
                if (fall_ev)
                begin
                    st_nxt.fall_cnt = st_r.fall_cnt + 3'h1;
                    if (st_r.fall_cnt + 3'h1 == `ACQ_FALL_EDGES)
                    begin
                        st_nxt.hold       = 1'b1;
                        st_nxt.conv_start = 1'b1;
                        st_nxt.phase      = adc_port_pkg::ST_CONVERT;
                    end
                end
            end
            adc_port_pkg::ST_TRACK_EXT:
            begin
                // The next write rise ends acquisition.
                if (wr_rise)
                begin
                    st_nxt.hold       = 1'b1;
                    st_nxt.conv_start = 1'b1;
                    st_nxt.phase      = adc_port_pkg::ST_CONVERT;
                end
            end
            adc_port_pkg::ST_CONVERT:
            begin
                // Writes are ignored while the core converts. The done set
                // is placed after the read clear so that it wins.
                if (core_done)
                begin
                    st_nxt.result = core_result;
                    st_nxt.done_n = 1'b0;
                    st_nxt.phase  = adc_port_pkg::ST_IDLE;
                end
            end
            default:
                st_nxt.phase = adc_port_pkg::ST_IDLE;
        endcase

        // Drive the data bus only while selected and reading; drive done while selected.
        st_nxt.data_oe = ~cs_s & ~rd_s;
        st_nxt.done_oe = ~cs_s;
        // Upper two bits land on the two lowest lines.
        if (hb_s)
            st_nxt.data_out = {6'h00, st_r.result[9:8]};
        else
            st_nxt.data_out = st_r.result[7:0];
    end

    // State register with synchronous reset.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r            <= '0;
            st_r.phase      <= adc_port_pkg::ST_IDLE;
            st_r.cfg        <= `CFG_RESET;
            st_r.result     <= `RESULT_RESET;
            st_r.done_n     <= 1'b1;
            st_r.wr_d       <= 1'b1;
            st_r.rd_d       <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign data_bus_lines_out = st_r.data_out;
    assign data_bus_lines_oe  = st_r.data_oe;
    assign conv_done_n_out    = st_r.done_n;
    assign conv_done_n_oe     = st_r.done_oe;
    assign track_hold         = st_r.hold;
    assign conv_start         = st_r.conv_start;
    assign config_byte        = st_r.cfg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Checks on the port's behaviour.
    bus_float_cs_a: assert property (cs_s |=> !data_bus_lines_oe
        && !conv_done_n_oe) else $error("outputs driven while deselected");
    read_drive_a: assert property (!cs_s && !rd_s |=>
        data_bus_lines_oe) else $error("read did not drive the bus");
    no_drive_rd_a: assert property (rd_s |=>
        !data_bus_lines_oe) else $error("bus driven with read high");
    high_byte_out_a: assert property (hb_s |=>
        data_bus_lines_out == {6'h00, $past(st_r.result[9:8])})
        else $error("high byte wrong");
    low_lines_a: assert property (!hb_s |=>
        data_bus_lines_out[1:0] == $past(st_r.result[1:0]))
        else $error("low byte bits wrong");
    done_set_a: assert property (st_r.phase == adc_port_pkg::ST_CONVERT
        && core_done |=> !conv_done_n_out) else $error("done not set");
    read_clear_a: assert property (st_r.rd_d && !rd_s && !cs_s
        && !core_done |=> conv_done_n_out) else $error("done not cleared");
    cfg_latch_a: assert property (st_r.phase == adc_port_pkg::ST_IDLE
        && !st_r.wr_d && wr_s && !cs_s |=> config_byte == $past(data_s)
        && !track_hold) else $error("config not latched");
    ext_hold_a: assert property (st_r.phase == adc_port_pkg::ST_TRACK_EXT
        && !st_r.wr_d && wr_s && !cs_s |=> track_hold && conv_start)
        else $error("external hold missed");
    int_hold_a: assert property (st_r.phase == adc_port_pkg::ST_TRACK_INT
        && st_r.fall_cnt != 3'h3 |=> !track_hold)
        else $error("hold before fourth edge");
    // The done output rises only through a read; the pin drives while selected.
    done_stays_a: assert property (
        !conv_done_n_out && !(st_r.rd_d && !rd_s && !cs_s)
        |=> !conv_done_n_out) else $error("done rose without a read");
    done_drive_a: assert property (!cs_s |=> conv_done_n_oe)
        else $error("done pin not driven while selected");
    low_byte_out_a: assert property (!hb_s |=>
        data_bus_lines_out == $past(st_r.result[7:0]))
        else $error("low byte wrong");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");

    ext_clk_c: cover property (ext_clk_mode && conv_start);

    int_conv_c: cover property (st_r.phase == adc_port_pkg::ST_TRACK_INT
        ##[1:200] conv_start);
    ext_conv_c: cover property (st_r.phase == adc_port_pkg::ST_TRACK_EXT
        ##[1:200] conv_start);
    read_high_c: cover property (!conv_done_n_out && hb_s && !rd_s && !cs_s);

endmodule // adc_byte_wide_host_port

// file: hdl/adc_port_defs.svh
// Constants of the byte-wide converter host port: field positions,
// reset values and counts. Assumes inclusion by the port's modules only.
//
// Behaviour
// - High-byte select chooses upper two or lower eight.
// - Two lowest lines carry bits 1:0 or 9:8.
// - Done output goes low when result ready.
// - Read strobe fall with select low drives data.
// - Internal mode: write rise latches config, starts acquisition.
// - External mode: second write rise starts the conversion.
// - Chip select high floats done and data.
// - Read strobe fall returns done output high.
// - Write rise tracks; external mode next rise holds.
// - Internal mode holds on fourth clock fall.
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

`define RESULT_W        10
`define BYTE_W          8
`define CFG_ACQ_BIT     5
`define ACQ_FALL_EDGES  3'h4
`define OSC_DIV_DEFAULT 8'h05
`define CFG_RESET       8'h00
`define RESULT_RESET    10'h000
`define SYNC_W          13
`define SYNC_RESET      13'h0700

`endif

// file: hdl/adc_port_pkg.sv
// Types shared by the converter host port.
// Assumes the constants header is compiled alongside.
package adc_port_pkg;

    // Phase of the acquisition and conversion sequence.
    typedef enum {ST_IDLE, ST_TRACK_INT, ST_TRACK_EXT, ST_CONVERT} phase_t;

    // Whole registered state of the port.
    typedef struct packed {
        phase_t      phase;
        logic [2:0]  fall_cnt;
        logic [7:0]  osc_cnt;
        logic [7:0]  cfg;
        logic [9:0]  result;
        logic        done_n;
        logic [7:0]  data_out;
        logic        data_oe;
        logic        done_oe;
        logic        hold;
        logic        conv_start;
        logic        wr_d;
        logic        rd_d;
        logic        clk_d;
    } port_state_t;

endpackage

// file: hdl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes every bit is independent; no bit is sampled coherently.
`timescale 1ns/1ps

module pin_sync #(
    parameter int          WIDTH   = 13,
    parameter logic [12:0] RST_VAL = 13'h0700
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out
);

    // One pair of flops per pin; only the second flop is read outside.
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic [1:0] stage_r;
        always_ff @(posedge ref_clk)
        begin
            if (rst)
                stage_r <= {2{RST_VAL[i]}};
            else
                stage_r <= {stage_r[0], pin_in[i]};
        end
        assign pin_sync_out[i] = stage_r[1];
    end

endmodule // pin_sync

// file: testbench/host_bus_model.sv
// Host processor model for the converter's byte-wide port.
// Assumes the port samples every pin through two flops.
`timescale 1ns/1ps

module host_bus_model (
    input  wire logic       ref_clk,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic            high_byte_select,
    output logic [7:0]      data_bus_lines_in,
    input  wire logic [7:0] data_bus_lines_out,
    input  wire logic       data_bus_lines_oe,
    input  wire logic       conv_done_n_out,
    input  wire logic       conv_done_n_oe
);
    logic [7:0] host_d = 8'h00;
    logic       done_pin;

    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        high_byte_select = 1'b0;
    end

    // Wire levels: the port wins while it drives, else the host value.
    assign data_bus_lines_in = data_bus_lines_oe ? data_bus_lines_out
                                                 : host_d;
    assign done_pin = conv_done_n_oe ? conv_done_n_out : 1'bz;

    // Strobe lasts four cycles and data outlives the rise, because the
    // port only sees the rise after its synchronisers.
    task automatic wr_byte(input logic [7:0] b);
        host_d <= b;
        cs_n   <= 1'b0;
        wr_n   <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cs_n   <= 1'b1;
        host_d <= ~b;
        @(posedge ref_clk);
    endtask

    // One read cycle; the bus and done pin are sampled as a host would.
    task automatic rd_byte(input logic hb, output logic [7:0] q,
                           output logic dn0, output logic dn1,
                           output logic oe1);
        high_byte_select <= hb;
        cs_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        dn0 = done_pin;
        rd_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        q   = data_bus_lines_in;
        dn1 = done_pin;
        rd_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        oe1 = data_bus_lines_oe;
        cs_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule // host_bus_model

// file: testbench/adc_byte_wide_host_port_bench.sv
// Self-checking bench of the converter host port.
// Assumes the host model file is compiled before it.
`timescale 1ns/1ps

module adc_byte_wide_host_port_bench;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       core_done = 1'b0;
    logic [9:0] core_result = 10'h000;
    logic       cs_n, rd_n, wr_n, hbs, d_oe, dn_out, dn_oe, th, cstart;
    logic [7:0] d_in, d_out, cfg;
    int         err_total = 0;
    int         num_checks = 0;
    logic       ext_mode = 1'b0;
    logic       conv_clk = 1'b0;
    logic [1:0] cdiv = 2'h0;
    int         start_count = 0;

    // Half period of the 40 MHz clock.
    always #12.5 ref_clk = ~ref_clk;

    // Host clock on the pin in external clock mode, eight system clocks
    // a period; tied low otherwise so no stray fall reaches the port.
    always @(posedge ref_clk)
    begin
        if (ext_mode)
        begin
            cdiv <= cdiv + 2'h1;
            if (cdiv == 2'h3)
                conv_clk <= ~conv_clk;
        end
        else
            conv_clk <= 1'b0;
    end

    // Counts start pulses, so a one-cycle pulse is never missed.
    always @(posedge ref_clk)
    begin
        if (cstart === 1'b1)
            start_count <= start_count + 1;
    end

    adc_byte_wide_host_port #(.OSC_DIV(8'h05)) u_adc_byte_wide_host_port (
        .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .high_byte_select(hbs), .data_bus_lines_in(d_in),
        .conv_clk_pin(conv_clk), .ext_clk_mode(ext_mode),
        .core_done(core_done),
        .core_result(core_result), .data_bus_lines_out(d_out),
        .data_bus_lines_oe(d_oe), .conv_done_n_out(dn_out),
        .conv_done_n_oe(dn_oe), .track_hold(th), .conv_start(cstart),
        .config_byte(cfg));

    host_bus_model u_host_bus_model (
        .ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .high_byte_select(hbs), .data_bus_lines_in(d_in),
        .data_bus_lines_out(d_out), .data_bus_lines_oe(d_oe),
        .conv_done_n_out(dn_out), .conv_done_n_oe(dn_oe));

    // Compares four-state values so an unknown never counts as a match.
    task automatic chk(input string nm, input logic [9:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Single place where the run ends.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Bounded wait until the given number of start pulses has been seen;
    // a hang ends the run.
    task automatic wait_start(input int want);
        int n;
        n = 0;
        while (start_count < want && n < 80)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (start_count < want)
        begin
            err_total++;
            complete_run();
        end
        @(posedge ref_clk);
        chk("hold after start", {9'h0, th}, 10'h001);
        chk("start pulses", 10'(start_count), 10'(want));
    endtask

    // Core finishes; with chip select high both outputs must float.
    task automatic finish_conv(input logic [9:0] r);
        core_done   <= 1'b1;
        core_result <= r;
        @(posedge ref_clk);
        core_done <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("done float", {9'h0, dn_oe}, 10'h000);
        chk("data float", {9'h0, d_oe}, 10'h000);
    endtask

    // High byte first, then low; done clears on the first read.
    task automatic read_both(input logic [9:0] r);
        logic [7:0] q;
        logic dn0, dn1, oe1;
        u_host_bus_model.rd_byte(1'b1, q, dn0, dn1, oe1);
        chk("high byte", {2'h0, q}, {8'h00, r[9:8]});
        chk("done low", {9'h0, dn0}, 10'h000);
        chk("done cleared", {9'h0, dn1}, 10'h001);
        chk("bus released", {9'h0, oe1}, 10'h000);
        u_host_bus_model.rd_byte(1'b0, q, dn0, dn1, oe1);
        chk("low byte", {2'h0, q}, {2'h0, r[7:0]});
        chk("done stays", {9'h0, dn0}, 10'h001);
    endtask

    // Internal acquisition: write, four clock falls, hold, convert, read.
    task automatic t_internal();
        u_host_bus_model.wr_byte(8'h1b);
        chk("config", {2'h0, cfg}, 10'h01b);
        chk("tracking", {9'h0, th}, 10'h000);
        wait_start(1);
        finish_conv(10'h2a5);
        read_both(10'h2a5);
        $display("internal acquisition test done");
    endtask

    // External acquisition: tracking lasts until the next write rise.
    task automatic t_external();
        u_host_bus_model.wr_byte(8'h20);
        chk("config ext", {2'h0, cfg}, 10'h020);
        repeat (40) @(posedge ref_clk);
        chk("still tracking", {9'h0, th}, 10'h000);
        u_host_bus_model.wr_byte(8'h33);
        chk("config kept", {2'h0, cfg}, 10'h020);
        wait_start(2);
        finish_conv(10'h15a);
        read_both(10'h15a);
        $display("external acquisition test done");
    endtask

    // External clock, internal acquisition: hold on the fourth pin fall.
    // Pin falls come eight cycles apart, so sixteen cycles after the
    // write at most three can have been counted.
    task automatic t_ext_clock();
        ext_mode <= 1'b1;
        @(posedge ref_clk);
        u_host_bus_model.wr_byte(8'h05);
        chk("config clk", {2'h0, cfg}, 10'h005);
        repeat (16) @(posedge ref_clk);
        chk("no early hold", {9'h0, th}, 10'h000);
        wait_start(3);
        finish_conv(10'h0c3);
        read_both(10'h0c3);
        ext_mode <= 1'b0;
        $display("external clock test done");
    endtask

    // Reset, then the scenarios in turn.
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("reset oe", {9'h0, d_oe}, 10'h000);
        chk("reset done", {9'h0, dn_oe}, 10'h000);
        $display("reset test done");
        t_internal();
        t_external();
        t_ext_clock();
        complete_run();
    end
endmodule // adc_byte_wide_host_port_bench
